// ==== src/acs_regs.svh ====
/*
 * Register offsets, field positions, reset values and timing constants
 * for the converter select-and-sleep sequencer.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef ACS_REGS_SVH
`define ACS_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define ACS_OFF_CTRL      8'h00
`define ACS_OFF_SEL       8'h04
`define ACS_OFF_STATUS    8'h08
`define ACS_OFF_SLEEP     8'h0c

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define ACS_CTRL_EN       0
`define ACS_CTRL_START    1
`define ACS_CTRL_ATE      2
`define ACS_CTRL_IE       3
`define ACS_CTRL_PS_LO    4
`define ACS_CTRL_PS_HI    6

// ----------------------------------------------------------------------
// Selection register fields
// ----------------------------------------------------------------------
`define ACS_SEL_MUX_LO    0
`define ACS_SEL_MUX_HI    4
`define ACS_SEL_REF_LO    6
`define ACS_SEL_REF_HI    7

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define ACS_ST_DONE       0
`define ACS_ST_BUSY       1
`define ACS_ST_LOCK       2
`define ACS_ST_RES_LO     16
`define ACS_ST_RES_HI     25

// ----------------------------------------------------------------------
// Reset values and conversion timing
// ----------------------------------------------------------------------
`define ACS_CTRL_RST      8'h00
`define ACS_SEL_RST       8'h00
`define ACS_CONV_CLKS     5'd13
`define ACS_FIRST_CLKS    5'd25
`define ACS_FULL_SCALE    10'h3ff

`endif

// ==== src/acs_pkg.sv ====
/*
 * Types for the converter select-and-sleep sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acs_pkg;

    // Reference source selection codes
    typedef enum logic [1:0] {
        ACS_REF_EXT  = 2'h0,
        ACS_REF_SUP  = 2'h1,
        ACS_REF_RSVD = 2'h2,
        ACS_REF_BG   = 2'h3
    } acs_ref_t;

    // Sleep request codes from the CPU
    typedef enum logic [2:0] {
        ACS_SLP_NONE,
        ACS_SLP_IDLE,
        ACS_SLP_NOISE,
        ACS_SLP_OTHER
    } acs_sleep_t;

    // Conversion sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_WAIT_EDGE,
        ACS_CONV
    } acs_state_t;

endpackage

// ==== src/acs_clkdiv.sv ====
/*
 * Prescaler that makes the converter clock as a one-cycle enable pulse.
 * Assumes one clock; held in reset while the converter is disabled.
 */
`timescale 1ns/100ps
`include "acs_regs.svh"

module acs_clkdiv
    import acs_pkg::*;
#(
    parameter int PS_W = 3
) (
    // Clock and reset
    input  wire logic            aclk,
    input  wire logic            aresetn,
    // Control
    input  wire logic            run,
    input  wire logic            restart,
    input  wire logic [PS_W-1:0] prescale,
    // Converter clock enable
    output logic                 tick
);

    logic [7:0] cnt_reg;
    logic [7:0] cnt_next;
    logic [7:0] limit;

    // Division ratio is two to the power of prescale, at least two
    always_comb begin
        limit    = (8'h01 << prescale) - 8'h01;
        if (limit == 8'h00) begin
            limit = 8'h01;
        end
        cnt_next = cnt_reg + 8'h01;
        if (!run || restart || cnt_reg == limit) begin
            cnt_next = 8'h00;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign tick = run && !restart && (cnt_reg == limit);

endmodule

// ==== src/acs_top.sv ====
/*
 * Converter selection and sleep sequencer with an AXI4-Lite slave.
 * Assumes a CPU sleep controller, a trigger source and an analog core
 * result input, all synchronous to aclk.
 */
`timescale 1ns/100ps
`include "acs_regs.svh"

module acs_top
    import acs_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Trigger, sleep and analog core
    input  wire logic        trigger_in,
    input  wire logic        cpu_halted,
    input  wire logic [2:0]  sleep_mode,
    input  wire logic [9:0]  analog_code,
    input  wire logic        over_reference,
    // Outputs to analog core and CPU
    output logic [4:0]       active_mux,
    output logic [1:0]       active_ref,
    output logic             conversion_done_irq
);

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [7:0]  ctrl_reg, ctrl_next;
    logic [7:0]  channel_select_reg, sel_next;
    logic [6:0]  lock_reg, lock_next;       // {ref, mux} used by analog
    logic        done_reg, done_next;
    logic        first_reg, first_next;
    logic [9:0]  result_reg, result_next;
    logic [4:0]  cyc_reg, cyc_next;
    acs_state_t  st_reg, st_next;
    logic        slp_arm_reg, slp_arm_next;
    logic        bvalid_reg, bvalid_next;
    logic        rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;

    logic        converter_enable, auto_trigger_enable, irq_en;
    logic        tick, restart, wr_go, rd_go, trig_start, sleep_start;
    logic [4:0]  conv_len;
    logic [6:0]  sel_fields;
    logic        conv_last;

    assign converter_enable    = ctrl_reg[`ACS_CTRL_EN];
    assign auto_trigger_enable = ctrl_reg[`ACS_CTRL_ATE];
    assign irq_en              = ctrl_reg[`ACS_CTRL_IE];

    // Trigger and sleep start sources
    assign trig_start  = converter_enable && auto_trigger_enable
                         && trigger_in && st_reg == ACS_IDLE;
    assign sleep_start = converter_enable && slp_arm_reg && cpu_halted
                         && st_reg == ACS_IDLE
                         && (sleep_mode == ACS_SLP_IDLE
                             || sleep_mode == ACS_SLP_NOISE);
    assign restart     = trig_start;

    // Converter clock enable from the prescaler
    acs_clkdiv #(.PS_W(3)) u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .run      (converter_enable),
        .restart  (restart),
        .prescale (ctrl_reg[`ACS_CTRL_PS_HI:`ACS_CTRL_PS_LO]),
        .tick     (tick)
    );

    assign wr_go   = s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    assign rd_go   = s_axi_arvalid && !rvalid_reg;
    assign conv_len = first_reg ? `ACS_FIRST_CLKS : `ACS_CONV_CLKS;

    // Stored selection fields and the last converter clock of a conversion
    assign sel_fields = {channel_select_reg[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO],
                         channel_select_reg[`ACS_SEL_MUX_HI:`ACS_SEL_MUX_LO]};
    assign conv_last  = st_reg == ACS_CONV && tick
                        && cyc_reg == conv_len - 5'd2;

    // ------------------------------------------------------------------
    // Next state: bus, sequencer, selection buffer
    // ------------------------------------------------------------------
    always_comb begin
        ctrl_next    = ctrl_reg;
        sel_next     = channel_select_reg;
        lock_next    = lock_reg;
        done_next    = done_reg;
        first_next   = first_reg;
        result_next  = result_reg;
        cyc_next     = cyc_reg;
        st_next      = st_reg;
        slp_arm_next = slp_arm_reg;
        bvalid_next  = bvalid_reg && !s_axi_bready;
        bresp_next   = bresp_reg;
        rvalid_next  = rvalid_reg && !s_axi_rready;
        rresp_next   = rresp_reg;
        rdata_next   = rdata_reg;
        // Register writes
        if (wr_go) begin
            bvalid_next = 1'b1;
            bresp_next  = 2'h0;
            if (s_axi_awaddr == `ACS_OFF_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    ctrl_next = s_axi_wdata[7:0];
                    // Start bit only sets; hardware clears it
                    ctrl_next[`ACS_CTRL_START] = ctrl_reg[`ACS_CTRL_START]
                        || s_axi_wdata[`ACS_CTRL_START];
                end
            end else if (s_axi_awaddr == `ACS_OFF_SEL) begin
                if (s_axi_wstrb[0]) begin
                    sel_next = s_axi_wdata[7:0];
                end
            end else if (s_axi_awaddr == `ACS_OFF_STATUS) begin
                // Write one clears the done flag
                if (s_axi_wstrb[0] && s_axi_wdata[`ACS_ST_DONE]) begin
                    done_next = 1'b0;
                end
            end else if (s_axi_awaddr == `ACS_OFF_SLEEP) begin
                if (s_axi_wstrb[0]) begin
                    slp_arm_next = s_axi_wdata[0];
                end
            end else begin
                bresp_next = 2'h3;
            end
        end
        // Selection buffer tracks while unlocked
        if (st_reg != ACS_CONV) begin
            lock_next = {sel_next[`ACS_SEL_REF_HI:`ACS_SEL_REF_LO],
                         sel_next[`ACS_SEL_MUX_HI:`ACS_SEL_MUX_LO]};
        end
        case (st_reg)
            ACS_IDLE: begin
                if (trig_start || sleep_start) begin
                    st_next  = ACS_CONV;
                    cyc_next = 5'd0;
                    ctrl_next[`ACS_CTRL_START] = 1'b1;
                    if (sleep_start) begin
                        slp_arm_next = 1'b0;
                    end
                end else if (ctrl_reg[`ACS_CTRL_START] && converter_enable) begin
                    st_next = ACS_WAIT_EDGE;
                end
            end
            ACS_WAIT_EDGE: begin
                if (tick) begin
                    st_next  = ACS_CONV;
                    cyc_next = 5'd0;
                end
            end
            ACS_CONV: begin
                if (tick) begin
                    cyc_next = cyc_reg + 5'd1;
                    // Last converter clock: tracking resumes
                    if (cyc_reg == conv_len - 5'd2) begin
                        st_next   = ACS_IDLE;
                        done_next = 1'b1;
                        first_next = 1'b0;
                        result_next = over_reference ?
                            `ACS_FULL_SCALE : analog_code;
                        lock_next = sel_fields;
                        // Free running chains on the selection at completion
                        if (auto_trigger_enable && trigger_in) begin
                            st_next  = ACS_CONV;
                            cyc_next = 5'd0;
                        end else begin
                            ctrl_next[`ACS_CTRL_START] = 1'b0;
                        end
                    end
                end
            end
            default: st_next = ACS_IDLE;
        endcase
        // Disable last so it aborts any sequencer step; next is extended
        if (!ctrl_next[`ACS_CTRL_EN]) begin
            first_next = 1'b1;
            st_next    = ACS_IDLE;
            ctrl_next[`ACS_CTRL_START] = 1'b0;
        end
        // Register reads
        if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next  = 2'h0;
            rdata_next  = 32'h0000_0000;
            if (s_axi_araddr == `ACS_OFF_CTRL) begin
                rdata_next[7:0] = ctrl_reg;
            end else if (s_axi_araddr == `ACS_OFF_SEL) begin
                rdata_next[7:0] = channel_select_reg;
            end else if (s_axi_araddr == `ACS_OFF_STATUS) begin
                rdata_next[`ACS_ST_DONE] = done_reg;
                rdata_next[`ACS_ST_BUSY] = ctrl_reg[`ACS_CTRL_START];
                rdata_next[`ACS_ST_LOCK] = (st_reg == ACS_CONV);
                rdata_next[`ACS_ST_RES_HI:`ACS_ST_RES_LO] = result_reg;
            end else if (s_axi_araddr == `ACS_OFF_SLEEP) begin
                rdata_next[0] = slp_arm_reg;
            end else begin
                rresp_next = 2'h3;
            end
        end
    end

    // Register all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg           <= `ACS_CTRL_RST;
            channel_select_reg <= `ACS_SEL_RST;
            lock_reg           <= 7'h00;
            done_reg           <= 1'b0;
            first_reg          <= 1'b1;
            result_reg         <= 10'h000;
            cyc_reg            <= 5'h00;
            st_reg             <= ACS_IDLE;
            slp_arm_reg        <= 1'b0;
            bvalid_reg         <= 1'b0;
            bresp_reg          <= 2'h0;
            rvalid_reg         <= 1'b0;
            rresp_reg          <= 2'h0;
            rdata_reg          <= 32'h0000_0000;
        end else begin
            ctrl_reg           <= ctrl_next;
            channel_select_reg <= sel_next;
            lock_reg           <= lock_next;
            done_reg           <= done_next;
            first_reg          <= first_next;
            result_reg         <= result_next;
            cyc_reg            <= cyc_next;
            st_reg             <= st_next;
            slp_arm_reg        <= slp_arm_next;
            bvalid_reg         <= bvalid_next;
            bresp_reg          <= bresp_next;
            rvalid_reg         <= rvalid_next;
            rresp_reg          <= rresp_next;
            rdata_reg          <= rdata_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign active_mux    = lock_reg[4:0];
    assign active_ref    = lock_reg[6:5];
    // Enable only gates; sleep mode never clears it
    assign conversion_done_irq = done_reg && irq_en;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    lock_holds_a: assert property (
        st_reg == ACS_CONV && $past(st_reg == ACS_CONV && !conv_last)
        |-> $stable(lock_reg))
        else $error("selection changed during conversion");
    start_edge_a: assert property (
        st_reg == ACS_WAIT_EDGE && tick && ctrl_next[`ACS_CTRL_EN]
        |=> st_reg == ACS_CONV && cyc_reg == 5'd0)
        else $error("start not taken on converter clock");
    trig_start_a: assert property (
        trig_start && ctrl_next[`ACS_CTRL_EN] |=> st_reg == ACS_CONV)
        else $error("trigger did not start conversion");
    sleep_start_a: assert property (
        sleep_start && ctrl_next[`ACS_CTRL_EN]
        |=> st_reg == ACS_CONV && !slp_arm_reg)
        else $error("sleep did not start conversion");
    irq_done_a: assert property (
        conv_last && ctrl_next[`ACS_CTRL_IE] |=> conversion_done_irq)
        else $error("completion interrupt missing");
    full_scale_a: assert property (
        conv_last && over_reference |=> result_reg == `ACS_FULL_SCALE)
        else $error("over-range code not full scale");
    sleep_keep_a: assert property (
        sleep_mode == ACS_SLP_OTHER && !wr_go && converter_enable
        |=> converter_enable)
        else $error("enable lost in sleep");
    track_sel_a: assert property (
        st_reg == ACS_IDLE && !$past(wr_go) |-> lock_reg == sel_fields)
        else $error("buffer not tracking selection");
    done_hold_a: assert property (done_reg && !wr_go |=> done_reg)
        else $error("done flag lost");
    free_run_a: assert property (
        conv_last && auto_trigger_enable && trigger_in
        && ctrl_next[`ACS_CTRL_EN]
        |=> st_reg == ACS_CONV && lock_reg == $past(sel_fields))
        else $error("free run not chained on held selection");

    conv_c:  cover property (st_reg == ACS_CONV ##1 st_reg == ACS_IDLE);
    sleep_c: cover property (sleep_start);
    trig_c:  cover property (trig_start);
    irq_c:   cover property ($rose(conversion_done_irq));

endmodule

// ==== verification/tb_top.sv ====
/*
 * Self-checking bench for the converter select-and-sleep sequencer.
 * Assumes acs_pkg and acs_regs.svh are compiled first; one 20 MHz clock.
 */
`timescale 1ns/100ps
`include "acs_regs.svh"

module tb_top
    import acs_pkg::*;
;
    // ------------------------------------------------------------------
    // Signals and scoreboard
    // ------------------------------------------------------------------
    typedef struct {
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0]  r;
    } acs_rexp_t;

    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp, active_ref;
    logic        trigger_in, cpu_halted, over_reference, irq;
    logic [2:0]  sleep_mode;
    logic [9:0]  analog_code, code;
    logic [4:0]  active_mux, mux, mux2;
    logic [31:0] rd;
    acs_rexp_t   rq[$];
    logic [1:0]  bq[$];
    acs_ref_t    refs[3] = '{ACS_REF_EXT, ACS_REF_SUP, ACS_REF_BG};
    int          n_errors, num_checks, cyc;

    acs_top acs_top_inst (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .trigger_in(trigger_in), .cpu_halted(cpu_halted),
        .sleep_mode(sleep_mode), .analog_code(analog_code),
        .over_reference(over_reference), .active_mux(active_mux),
        .active_ref(active_ref), .conversion_done_irq(irq)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (n_errors == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Write: address and data together, held until taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] rs);
        logic hit;
        bq.push_back(rs);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(negedge aclk);
            hit = awready && wready;
            @(posedge aclk);
        end while (!hit);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        do begin
            @(negedge aclk);
            hit = bvalid;
            @(posedge aclk);
        end while (!hit);
        bready <= 1'b0;
        // Idle edge before the next request
        @(posedge aclk);
    endtask

    // Read: expectation noted first, data returned for polling
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [31:0] m, input logic [1:0] rs,
                          output logic [31:0] d);
        logic hit;
        rq.push_back(acs_rexp_t'{e, m, rs});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(negedge aclk);
            hit = arready;
            @(posedge aclk);
        end while (!hit);
        arvalid <= 1'b0;
        do begin
            @(negedge aclk);
            hit = rvalid;
            d = rdata;
            @(posedge aclk);
        end while (!hit);
        rready <= 1'b0;
        // Idle edge before the next request
        @(posedge aclk);
    endtask

    task automatic wait_done();
        logic [31:0] d;
        d = '0;
        while (d[`ACS_ST_DONE] !== 1'b1) begin
            axi_rd(`ACS_OFF_STATUS, '0, '0, 2'b00, d);
        end
    endtask

    // ------------------------------------------------------------------
    // Clock, timeout and response monitor
    // ------------------------------------------------------------------
    always #25 aclk = ~aclk;

    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            complete_run();
        end
    end

    // Oldest note compared whenever a response is handed over
    always @(negedge aclk) begin
        acs_rexp_t re;
        if (rvalid && rready && rq.size() > 0) begin
            re = rq.pop_front();
            chk(rdata & re.m, re.d);
            chk(32'(rresp), 32'(re.r));
        end
        if (bvalid && bready && bq.size() > 0) begin
            chk(32'(bresp), 32'(bq.pop_front()));
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata, trigger_in, cpu_halted} = '0;
        {sleep_mode, analog_code, over_reference} = '0;
        wstrb = 4'hf;
        void'($urandom(22));
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        // Reset values and an unmapped place
        axi_rd(`ACS_OFF_CTRL, '0, '1, 2'b00, rd);
        axi_rd(`ACS_OFF_SEL, '0, '1, 2'b00, rd);
        axi_rd(`ACS_OFF_STATUS, '0, '1, 2'b00, rd);
        axi_rd(8'h10, '0, '1, 2'b11, rd);
        axi_wr(8'h10, 32'h0000_00ff, 2'b11);
        chk(32'({active_mux, active_ref, irq}), '0);
        // Single-ended conversions per reference; no gain settling
        for (int i = 0; i < 3; i++) begin
            mux  = 5'($urandom);
            mux2 = ~mux;
            code = 10'($urandom);
            analog_code    <= code;
            over_reference <= (i == 2);
            axi_wr(`ACS_OFF_SEL, {24'h0, refs[i], 1'b0, mux}, 2'b00);
            axi_wr(`ACS_OFF_CTRL, 32'h0000_001b, 2'b00);
            repeat (4) @(posedge aclk);
            axi_wr(`ACS_OFF_SEL, {24'h0, refs[i], 1'b0, mux2}, 2'b00);
            chk(32'(active_mux), 32'(mux));
            chk(32'(active_ref), 32'(refs[i]));
            wait_done();
            if (i == 2) code = `ACS_FULL_SCALE;
            axi_rd(`ACS_OFF_STATUS, {6'h0, code, 16'h1}, 32'h03ff_0003,
                   2'b00, rd);
            chk(32'(irq), 32'h1);
            chk(32'(active_mux), 32'(mux2));
            axi_wr(`ACS_OFF_STATUS, 32'h1, 2'b00);
            chk(32'(irq), 32'h0);
        end
        over_reference <= 1'b0;
        // Sleep-started conversions, idle mode woken early by another source
        for (int m = 1; m <= 2; m++) begin
            code = 10'($urandom);
            analog_code <= code;
            axi_wr(`ACS_OFF_SLEEP, 32'h1, 2'b00);
            sleep_mode <= 3'(m);
            cpu_halted <= 1'b1;
            repeat (3) @(posedge aclk);
            if (m == 1) cpu_halted <= 1'b0;
            wait_done();
            chk(32'(irq), 32'h1);
            axi_rd(`ACS_OFF_STATUS, {6'h0, code, 16'h0}, 32'h03ff_0000,
                   2'b00, rd);
            axi_wr(`ACS_OFF_STATUS, 32'h1, 2'b00);
            cpu_halted <= 1'b0;
            sleep_mode <= 3'h0;
        end
        // Other sleep modes start nothing and keep the converter on
        axi_wr(`ACS_OFF_SLEEP, 32'h1, 2'b00);
        sleep_mode <= 3'h3;
        cpu_halted <= 1'b1;
        repeat (20) @(posedge aclk);
        axi_rd(`ACS_OFF_STATUS, '0, 32'h3, 2'b00, rd);
        axi_rd(`ACS_OFF_CTRL, 32'h1, 32'h1, 2'b00, rd);
        cpu_halted <= 1'b0;
        sleep_mode <= 3'h0;
        axi_wr(`ACS_OFF_SLEEP, 32'h0, 2'b00);
        axi_wr(`ACS_OFF_CTRL, 32'h0, 2'b00);
        // Free running by a held trigger; new channel skips one conversion
        mux  = 5'h03;
        mux2 = 5'h1c;
        axi_wr(`ACS_OFF_SEL, {24'h0, 8'(mux)}, 2'b00);
        axi_wr(`ACS_OFF_CTRL, 32'h0000_001d, 2'b00);
        trigger_in <= 1'b1;
        wait_done();
        axi_wr(`ACS_OFF_SEL, {24'h0, 8'(mux2)}, 2'b00);
        axi_wr(`ACS_OFF_STATUS, 32'h1, 2'b00);
        chk(32'(active_mux), 32'(mux));
        wait_done();
        chk(32'(active_mux), 32'(mux2));
        trigger_in <= 1'b0;
        axi_wr(`ACS_OFF_CTRL, 32'h0, 2'b00);
        repeat (4) @(posedge aclk);
        complete_run();
    end
endmodule
